// ---- hw/tbdiv_consts.svh ----
// Address map, field positions, reset values and divider taps of the time base block
`ifndef TBDIV_CONSTS_SVH
`define TBDIV_CONSTS_SVH

`define TBDIV_ADDR_W 8
`define TBDIV_DATA_W 8
`define TBDIV_ADDR_CTRL 8'h36
`define TBDIV_ADDR_STAT 8'h37
`define TBDIV_ADDR_MASK 8'h38
`define TBDIV_CTRL_RESET 8'h00
`define TBDIV_STAT_RESET 8'h00
`define TBDIV_MASK_RESET 8'h00
`define TBDIV_UNMAPPED_READ 8'h00

`define TBDIV_BIT_TICK_EN 3
`define TBDIV_BIT_BUZ_EN 7
`define TBDIV_BIT_TICK_EVT 0

`define TBDIV_DIV_W 23
`define TBDIV_TICK_TAP0 5'h16
`define TBDIV_TICK_TAP1 5'h14
`define TBDIV_TICK_TAP2 5'h0F
`define TBDIV_TICK_TAP3 5'h0D
`define TBDIV_TICK_TAP4 5'h0C
`define TBDIV_TICK_TAP5 5'h0B
`define TBDIV_TICK_TAP6 5'h0A
`define TBDIV_TICK_TAP7 5'h08
`define TBDIV_BUZ_TAP0 5'h0C
`define TBDIV_BUZ_TAP1 5'h0B
`define TBDIV_BUZ_TAP2 5'h0A
`define TBDIV_BUZ_TAP3 5'h09

`endif

// ---- hw/tbdiv_pkg.sv ----
// Types shared by the time base timer and divider output block
package tbdiv_pkg;

    typedef logic [2:0] tbdiv_rate_t;
    typedef logic [1:0] tbdiv_freq_t;

    typedef struct packed {
        logic buzzer_out_enable;
        tbdiv_freq_t buzzer_freq_sel;
        logic reserved;
        logic tick_enable;
        tbdiv_rate_t tick_rate_sel;
    } tbdiv_ctrl_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tbdiv_bus_req_s;

endpackage

// ---- hw/tbdiv_top.sv ----
// Time base timer with periodic tick interrupt and square-wave buzzer divider output
//
// Contract
// - Rate code 000..111 taps fc/2^23..fc/2^9.
// - One write may set rate and enable.
// - Tick fires at first selected tap fall.
// - Divider cleared only by reset; first tick early.
// - Enable bit 3, rate select bits 2:0.
// - Enabled output drives ~50% square wave, active low.
// - Buzzer enable at bit 7, same register.
// - Control at 36h, resets to zero.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "tbdiv_consts.svh"

module tbdiv_top (
    input wire logic clock,
    input wire logic rstn,
    input wire tbdiv_pkg::tbdiv_bus_req_s bus_req,
    output logic [7:0] bus_rdata,
    output logic tick_irq,
    output logic tick_pulse,
    output logic buzzer_out_n
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release
    // Release is synchronised so every flop reset by rst_n leaves reset on the same edge
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////////
    // Register file
    tbdiv_pkg::tbdiv_ctrl_s ctrl_q;
    tbdiv_pkg::tbdiv_ctrl_s ctrl_d;
    logic [7:0] stat_q;
    logic [7:0] stat_d;
    logic [7:0] stat_clr;
    logic [7:0] mask_q;
    logic [7:0] mask_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;
    logic [7:0] rd_mux;
    logic [7:0] evt_set;

    // Writes to unmapped addresses fall through and change nothing
    always_comb begin
        wr_ctrl = 1'b0;
        wr_stat = 1'b0;
        wr_mask = 1'b0;
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                `TBDIV_ADDR_CTRL: begin
                    wr_ctrl = 1'b1;
                end
                `TBDIV_ADDR_STAT: begin
                    wr_stat = 1'b1;
                end
                `TBDIV_ADDR_MASK: begin
                    wr_mask = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // Enable and selects load together in one write, so enabling with a new rate is safe
    // Reserved bit 4 is never stored and reads zero
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = bus_req.wdata & 8'hEF;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `TBDIV_CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    always_comb begin
        mask_d = mask_q;
        if (wr_mask) begin
            mask_d = bus_req.wdata;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= `TBDIV_MASK_RESET;
        end else begin
            mask_q <= mask_d;
        end
    end

    // Write one to clear; a new event in the same cycle wins over the clear
    always_comb begin
        stat_clr = 8'h00;
        if (wr_stat) begin
            stat_clr = bus_req.wdata;
        end
        stat_d = (stat_q & ~stat_clr) | evt_set;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= `TBDIV_STAT_RESET;
        end else begin
            stat_q <= stat_d;
        end
    end

    always_comb begin
        unique case (bus_req.addr)
            `TBDIV_ADDR_CTRL: begin
                rd_mux = ctrl_q;
            end
            `TBDIV_ADDR_STAT: begin
                rd_mux = stat_q;
            end
            `TBDIV_ADDR_MASK: begin
                rd_mux = mask_q;
            end
            default: begin
                rd_mux = `TBDIV_UNMAPPED_READ;
            end
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_comb begin
        rdata_d = 8'h00;
        if (bus_req.rd) begin
            rdata_d = rd_mux;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign bus_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Free-running divider of fc
    logic [`TBDIV_DIV_W-1:0] div_q;
    logic [`TBDIV_DIV_W-1:0] div_d;
    logic [`TBDIV_DIV_W-1:0] div_fall;

    assign div_d = div_q + 23'h000001;

    // Only reset clears it: register writes leave the phase alone, so the first tick may come early
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 23'h000000;
        end else begin
            div_q <= div_d;
        end
    end

    // A tap falls when its bit goes from one to zero on the next count
    genvar gi;
    generate
        for (gi = 0; gi < `TBDIV_DIV_W; gi++) begin : g_fall
            assign div_fall[gi] = div_q[gi] & ~div_d[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Time base tick
    logic [4:0] tick_tap;
    logic tick_evt;
    logic tick_pulse_q;
    logic irq_q;
    logic irq_d;

    always_comb begin
        unique case (ctrl_q.tick_rate_sel)
            3'h0: begin
                tick_tap = `TBDIV_TICK_TAP0;
            end
            3'h1: begin
                tick_tap = `TBDIV_TICK_TAP1;
            end
            3'h2: begin
                tick_tap = `TBDIV_TICK_TAP2;
            end
            3'h3: begin
                tick_tap = `TBDIV_TICK_TAP3;
            end
            3'h4: begin
                tick_tap = `TBDIV_TICK_TAP4;
            end
            3'h5: begin
                tick_tap = `TBDIV_TICK_TAP5;
            end
            3'h6: begin
                tick_tap = `TBDIV_TICK_TAP6;
            end
            3'h7: begin
                tick_tap = `TBDIV_TICK_TAP7;
            end
        endcase
    end

    // Rate is read live; software keeps it steady while enabled, else a spurious fall may tick
    assign tick_evt = ctrl_q.tick_enable & div_fall[tick_tap];

    always_comb begin
        evt_set = 8'h00;
        evt_set[`TBDIV_BIT_TICK_EVT] = tick_evt;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tick_pulse_q <= 1'b0;
        end else begin
            tick_pulse_q <= tick_evt;
        end
    end

    // Level request follows the sticky flag in the same cycle, and a mask write one cycle later
    assign irq_d = |(stat_d & mask_q);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    assign tick_pulse = tick_pulse_q;
    assign tick_irq = irq_q;

    ////////////////////////////////////////////////////////////////////////
    // Buzzer divider output
    logic [4:0] buz_tap;
    logic buz_q;
    logic buz_d;

    always_comb begin
        unique case (ctrl_q.buzzer_freq_sel)
            2'h0: begin
                buz_tap = `TBDIV_BUZ_TAP0;
            end
            2'h1: begin
                buz_tap = `TBDIV_BUZ_TAP1;
            end
            2'h2: begin
                buz_tap = `TBDIV_BUZ_TAP2;
            end
            2'h3: begin
                buz_tap = `TBDIV_BUZ_TAP3;
            end
        endcase
    end

    // A divider bit is high half its period; idle pin rests high since it is active low
    // A select change while enabled may glitch the pin once
    always_comb begin
        buz_d = 1'b1;
        if (ctrl_q.buzzer_out_enable) begin
            buz_d = ~div_q[buz_tap];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            buz_q <= 1'b1;
        end else begin
            buz_q <= buz_d;
        end
    end

    assign buzzer_out_n = buz_q;

endmodule

// ---- tb/tbdiv_bench.sv ----
// Self-checking bench for the time base block
`timescale 1ns/1ps
module tbdiv_bench;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic rd_late = 1'b0;
    tbdiv_pkg::tbdiv_bus_req_s bus_req = '0;
    logic [7:0] bus_rdata, d;
    logic tick_irq, tick_pulse, buzzer_out_n;
    int half_len, tick_gap, n, err_total = 0, compares = 0;
    logic [7:0] exp_q[$];
    tbdiv_top dut (.clock, .rstn, .bus_req, .bus_rdata, .tick_irq, .tick_pulse, .buzzer_out_n);
    tbdiv_far_end far (.clock, .tick_pulse, .buzzer_out_n, .half_len, .tick_gap);
    initial forever #20 clock = ~clock;
    initial begin
        #2800000;
        err_total++;
        print_verdict();
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("mismatch at %0t: %0h not %0h", $time, g, e);
        end
    endtask
    // Strobes stay up until the next request or idle, so none is set twice in a step
    task automatic bus(input logic [7:0] a, input logic [7:0] w, input logic wr);
        bus_req <= '{a, w, wr, !wr};
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(a, 8'h00, 1'b0);
    endtask
    task automatic idle(input int k);
        bus_req.wr <= 1'b0;
        bus_req.rd <= 1'b0;
        repeat (k) @(posedge clock);
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////
    always @(posedge clock) rd_late <= bus_req.rd;
    always @(negedge clock) if (rd_late) chk(bus_rdata, exp_q.pop_front());
    initial begin
        void'($urandom(61));
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        rd(8'h36, 8'h00);
        rd(8'h37, 8'h00);
        rd(8'h40, 8'h00);
        repeat (3) begin
            d = 8'($urandom()) & 8'h77;
            bus(8'h36, d | 8'h88, 1'b1);
            rd(8'h36, (d | 8'h88) & 8'hEF);
            bus(8'h36, d, 1'b1);
            rd(8'h36, d & 8'hEF);
        end
        idle(2);
        $display("end registers");
        for (int b = 0; b < 4; b++) begin
            bus(8'h36, {1'b0, 2'(b), 5'h00}, 1'b1);
            bus(8'h36, {1'b1, 2'(b), 5'h00}, 1'b1);
            idle(3 << (12 - b));
            chk(half_len, 1 << (12 - b));
            bus(8'h36, {1'b0, 2'(b), 5'h00}, 1'b1);
            idle(2);
            chk(buzzer_out_n, 1'b1);
        end
        $display("end buzzer");
        bus(8'h37, 8'h01, 1'b1);
        bus(8'h38, 8'h01, 1'b1);
        for (int c = 4; c < 8; c++) begin
            bus(8'h36, {5'h01, 3'(c)}, 1'b1);
            idle(1);
            // First tick may come early, so only the second gap is judged
            repeat (2) begin
                n = 0;
                do @(negedge clock); while (tick_pulse !== 1'b1 && ++n < 9000);
                @(posedge clock);
            end
            // The far end latches the gap on this edge, so look after it settles
            @(negedge clock);
            chk(tick_gap, 1 << (c == 7 ? 9 : 17 - c));
            chk(tick_irq, 1'b1);
            @(posedge clock);
            rd(8'h37, 8'h01);
            bus(8'h36, {5'h00, 3'(c)}, 1'b1);
            bus(8'h37, 8'h01, 1'b1);
            idle(2);
            chk(tick_irq, 1'b0);
        end
        $display("end tick");
        print_verdict();
    end
endmodule

// ---- tb/tbdiv_far_end.sv ----
// Buzzer and tick pulse side: measures pin half period and tick spacing
`timescale 1ns/1ps
module tbdiv_far_end (
    input wire logic clock,
    input wire logic tick_pulse,
    input wire logic buzzer_out_n,
    output int half_len,
    output int tick_gap
);
    int bz_cnt, tk_cnt;
    logic bz_last;
    always @(posedge clock) begin
        bz_last <= buzzer_out_n;
        bz_cnt <= (bz_last !== buzzer_out_n) ? 1 : bz_cnt + 1;
        tk_cnt <= tick_pulse ? 1 : tk_cnt + 1;
        if (bz_last !== buzzer_out_n) half_len <= bz_cnt;
        if (tick_pulse) tick_gap <= tk_cnt;
    end
endmodule

// ---- tb/tbdiv_properties.sv ----
// Port-level assertions for the time base block
`timescale 1ns/1ps
module tbdiv_properties (
    input wire logic clock,
    input wire logic rstn,
    input wire tbdiv_pkg::tbdiv_bus_req_s bus_req,
    input wire logic [7:0] bus_rdata,
    input wire logic tick_irq,
    input wire logic tick_pulse,
    input wire logic buzzer_out_n
);
    // Shadow of the control register, rebuilt from bus writes
    logic [7:0] ctrl_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) ctrl_q <= 8'h00;
        else if (bus_req.wr && bus_req.addr == 8'h36) ctrl_q <= bus_req.wdata;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence clr_s;
        bus_req.wr && bus_req.addr == 8'h37 && bus_req.wdata[0] ##1 !tick_pulse [*2];
    endsequence
    rd_idle_a: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00) else $error("stray rdata");
    rd_ctrl_a: assert property (
        bus_req.rd && bus_req.addr == 8'h36 |=> bus_rdata == (ctrl_q & 8'hEF)) else $error("ctrl readback");
    buz_off_a: assert property (!ctrl_q[7] |=> buzzer_out_n) else $error("buzzer on");
    tick_off_a: assert property (!ctrl_q[3] [*2] |-> !tick_pulse) else $error("tick off");
    pulse_one_a: assert property (tick_pulse |=> !tick_pulse [*8]) else $error("pulse");
    irq_clr_a: assert property (clr_s |-> !tick_irq) else $error("irq kept");
    irq_rise_a: assert property (
        $rose(tick_irq) && !$past(bus_req.wr) && !$past(bus_req.wr, 2) |-> tick_pulse) else $error("irq rise");
    irq_hold_a: assert property (
        tick_irq && !bus_req.wr && !$past(bus_req.wr) |=> tick_irq) else $error("irq drop");
endmodule
////////////////////////////////////////
bind tbdiv_top tbdiv_properties props (.clock, .rstn, .bus_req, .bus_rdata, .tick_irq, .tick_pulse, .buzzer_out_n);
